//--- rtl/supdc_pkg.sv
// shared constants for the presettable up/down counter
package supdc_pkg;

    // =========================================================
    // widths and count limits
    localparam int unsigned  COUNT_WIDTH  = 4;
    localparam logic [3:0]   COUNT_ZERO   = 4'h0;
    localparam logic [3:0]   COUNT_ONE    = 4'h1;
    localparam logic [3:0]   DECADE_MAX   = 4'h9;
    localparam logic [3:0]   BINARY_MAX   = 4'hf;

    // =========================================================
    // values after reset
    localparam logic [3:0]   COUNT_RESET  = 4'h0;
    localparam logic [1:0]   MODE_RESET   = 2'h0;

    // =========================================================
    // operating mode taken at each edge
    typedef enum logic [1:0] {
        SUPDC_HOLD = 2'b00,
        SUPDC_LOAD = 2'b01,
        SUPDC_UP   = 2'b10,
        SUPDC_DOWN = 2'b11
    } supdc_mode_t;

endpackage

//--- rtl/supdc_counter.sv
// four-bit synchronous presettable up/down counter with look-ahead carry
// How it works
// - all four state bits change together on the rising clock edge, or clear at once when reset_n goes low.
// - decade variant counts 0 to 9, binary variant counts 0 to 15.
// - load low at an edge with clockEnable high copies the four data inputs into the state.
// - each state bit presets independently, so any pattern can load.
// - without load, count only when both active-low enables are low, else hold.
// - direction high counts up, low counts down, sampled at the edge.
// - carry output is gated by the trailing-stage enable only.
// - carry low at maximum counting up or zero counting down, else high.
// - decade variant wraps nine to zero up and zero to nine down.
// - binary variant wraps fifteen to zero up and zero to fifteen down.
// - load, enable and direction changes reach the state only at the next clock edge.
// - carry is combinational from state, direction and trailing enable.
`timescale 1ns/1ps
module supdc_counter
    import supdc_pkg::*;
#(
    parameter bit IS_DECADE = 1'b0          // 1: decade variant, 0: binary
) (
    input  wire logic clock,                    // rising-edge clock
    input  wire logic reset_n,                  // async reset, active low
    input  wire logic clockEnable,              // freezes all state when low
    input  wire logic load_n,                   // synchronous load, active low
    input  wire logic dataBit0,                 // preset data bit 0
    input  wire logic dataBit1,                 // preset data bit 1
    input  wire logic dataBit2,                 // preset data bit 2
    input  wire logic dataBit3,                 // preset data bit 3
    input  wire logic countUp,                  // 1 up, 0 down
    input  wire logic parallel_count_enable_n,  // count enable, active low
    input  wire logic trickle_count_enable_n,   // count and carry enable, active low
    output logic      count_bit0,               // state bit 0
    output logic      count_bit1,               // state bit 1
    output logic      count_bit2,               // state bit 2
    output logic      count_bit3,               // state bit 3
    output logic      ripple_carry_out_n        // carry, active low
);

    // =========================================================
    // declarations
    logic [3:0]  countState;
    logic [3:0]  presetData;
    logic [3:0]  next_countState;
    logic [3:0]  countMax;
    logic        atMax;
    logic        atZero;
    supdc_mode_t mode;

    assign countMax = IS_DECADE ? DECADE_MAX : BINARY_MAX;
    assign atMax    = (countState == countMax);
    assign atZero   = (countState == COUNT_ZERO);

    // =========================================================
    // per-bit preset path
    genvar b;
    generate
        for (b = 0; b < COUNT_WIDTH; b++) begin : g_preset
            assign presetData[b] = (b == 0) ? dataBit0 :
                                   (b == 1) ? dataBit1 :
                                   (b == 2) ? dataBit2 : dataBit3;
        end
    endgenerate

    // =========================================================
    // mode decode, acts only at the coming edge
    always_comb begin
        if (!load_n) begin
            mode = SUPDC_LOAD;
        end else if (!parallel_count_enable_n && !trickle_count_enable_n) begin
            mode = countUp ? SUPDC_UP : SUPDC_DOWN;
        end else begin
            mode = SUPDC_HOLD;
        end
    end

    // =========================================================
    // next state
    always_comb begin
        unique case (mode)
            SUPDC_LOAD: begin
                next_countState = presetData;
            end
            SUPDC_UP: begin
                if (countState >= countMax) begin
                    next_countState = COUNT_ZERO;
                end else begin
                    next_countState = countState + COUNT_ONE;
                end
            end
            SUPDC_DOWN: begin
                if (atZero) begin
                    next_countState = countMax;
                end else begin
                    next_countState = countState - COUNT_ONE;
                end
            end
            SUPDC_HOLD: begin
                next_countState = countState;
            end
        endcase
    end

    // =========================================================
    // state register, all bits on one edge
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            countState <= COUNT_RESET;
        end else if (clockEnable) begin
            countState <= next_countState;
        end
    end

    assign count_bit0 = countState[0];
    assign count_bit1 = countState[1];
    assign count_bit2 = countState[2];
    assign count_bit3 = countState[3];

    // =========================================================
    // look-ahead carry, follows direction and enable at once
    always_comb begin
        if (trickle_count_enable_n) begin
            ripple_carry_out_n = 1'b1;
        end else begin
            ripple_carry_out_n = !((countUp && atMax) || (!countUp && atZero));
        end
    end

    // =========================================================
    // checks
    logic [3:0] expectUp;
    logic [3:0] expectDown;
    logic [3:0] countSeen;

    assign countSeen  = {count_bit3, count_bit2, count_bit1, count_bit0};
    assign expectUp   = (countSeen >= countMax) ? COUNT_ZERO : countSeen + COUNT_ONE;
    assign expectDown = (countSeen == COUNT_ZERO) ? countMax : countSeen - COUNT_ONE;

    a_load_copies_data: assert property (
        @(posedge clock) disable iff (!reset_n)
        (clockEnable && !load_n)
        |=> countSeen == $past({dataBit3, dataBit2, dataBit1, dataBit0}))
        else $error("load did not copy the preset data");

    a_inhibit_holds_count: assert property (
        @(posedge clock) disable iff (!reset_n)
        (clockEnable && load_n && (parallel_count_enable_n || trickle_count_enable_n))
        |=> $stable(countSeen))
        else $error("count moved while inhibited");

    a_count_up_step: assert property (
        @(posedge clock) disable iff (!reset_n)
        (clockEnable && load_n && !parallel_count_enable_n
            && !trickle_count_enable_n && countUp)
        |=> countSeen == $past(expectUp))
        else $error("up count gave the wrong value");

    a_count_down_step: assert property (
        @(posedge clock) disable iff (!reset_n)
        (clockEnable && load_n && !parallel_count_enable_n
            && !trickle_count_enable_n && !countUp)
        |=> countSeen == $past(expectDown))
        else $error("down count gave the wrong value");

    a_wrap_up_zero: assert property (
        @(posedge clock) disable iff (!reset_n)
        (clockEnable && load_n && !parallel_count_enable_n
            && !trickle_count_enable_n && countUp && countSeen == countMax)
        |=> countSeen == COUNT_ZERO)
        else $error("up count did not wrap to zero");

    a_wrap_down_max: assert property (
        @(posedge clock) disable iff (!reset_n)
        (clockEnable && load_n && !parallel_count_enable_n
            && !trickle_count_enable_n && !countUp && countSeen == COUNT_ZERO)
        |=> countSeen == countMax)
        else $error("down count did not wrap to maximum");

    a_carry_gated_off: assert property (
        @(posedge clock) disable iff (!reset_n)
        trickle_count_enable_n |-> ripple_carry_out_n)
        else $error("carry low while trickle enable high");

    a_carry_terminal: assert property (
        @(posedge clock) disable iff (!reset_n)
        !trickle_count_enable_n
        |-> (ripple_carry_out_n
             == !((countUp && countSeen == countMax) || (!countUp && countSeen == COUNT_ZERO))))
        else $error("carry does not match terminal count");

    a_carry_ends_wrap: assert property (
        @(posedge clock) disable iff (!reset_n)
        (clockEnable && load_n && !parallel_count_enable_n
            && !trickle_count_enable_n && !ripple_carry_out_n
            && $stable(countUp))
        ##1 ($stable(countUp) && !trickle_count_enable_n)
        |-> ripple_carry_out_n)
        else $error("carry stayed low after the wrap");

    a_freeze_holds: assert property (
        @(posedge clock) disable iff (!reset_n)
        !clockEnable |=> $stable(countSeen))
        else $error("state changed with clock enable low");

    a_decade_in_range: assert property (
        @(posedge clock) disable iff (!reset_n)
        (IS_DECADE && countSeen <= DECADE_MAX && load_n) |=> countSeen <= DECADE_MAX)
        else $error("decade count left its range");

    a_above_nine_up: assert property (
        @(posedge clock) disable iff (!reset_n)
        (IS_DECADE && clockEnable && load_n && !parallel_count_enable_n
            && !trickle_count_enable_n && countUp && countSeen > DECADE_MAX)
        |=> countSeen == COUNT_ZERO)
        else $error("decade count above nine did not return to zero");

    a_carry_at_zero: assert property (
        @(posedge clock) disable iff (!reset_n)
        (!trickle_count_enable_n && countSeen == COUNT_ZERO) |-> ripple_carry_out_n == countUp)
        else $error("carry did not follow direction at zero");

endmodule

//--- testbench/supdc_chain_link.sv
// cascade link model: carry of the lower stage drives the upper stage enables
`timescale 1ns/1ps
module supdc_chain_link (
    input  wire logic carryIn_n,    // lower stage carry, active low
    output logic      enableOut_n   // upper stage count enables, active low
);
    assign enableOut_n = carryIn_n;
endmodule

//--- testbench/supdc_counter_test.sv
// testbench: decade stage cascaded into binary stage, directed and random stimulus
`timescale 1ns/1ps
module supdc_counter_test;
    import supdc_pkg::*;
    logic       clock       = 1'b0;
    logic       reset_n     = 1'b0;
    logic       clockEnable = 1'b1;
    logic       load_n      = 1'b1;
    logic       reload      = 1'b0;
    logic [3:0] data        = 4'h0;
    logic       countUp     = 1'b1;
    logic       enP_n       = 1'b1;
    logic       enT_n       = 1'b1;
    logic [3:0] qD, qB, expD, expB;
    logic       carryD_n, carryB_n, linkEn_n, loadPin_n;
    int         bad_count       = 0;
    int         samples_checked = 0;
    int         cycles          = 0;

    always #20 clock = ~clock;

    // =========================================
    // low decade stage, link, high binary stage
    assign loadPin_n = reload ? carryB_n : load_n;
    supdc_counter #(.IS_DECADE(1'b1)) u_low (.clock(clock), .reset_n(reset_n),
        .clockEnable(clockEnable), .load_n(loadPin_n), .dataBit0(data[0]), .dataBit1(data[1]),
        .dataBit2(data[2]), .dataBit3(data[3]), .countUp(countUp),
        .parallel_count_enable_n(enP_n), .trickle_count_enable_n(enT_n), .count_bit0(qD[0]),
        .count_bit1(qD[1]), .count_bit2(qD[2]), .count_bit3(qD[3]),
        .ripple_carry_out_n(carryD_n));
    supdc_chain_link u_link (.carryIn_n(carryD_n), .enableOut_n(linkEn_n));
    supdc_counter #(.IS_DECADE(1'b0)) u_dut (.clock(clock), .reset_n(reset_n),
        .clockEnable(clockEnable), .load_n(loadPin_n), .dataBit0(data[0]), .dataBit1(data[1]),
        .dataBit2(data[2]), .dataBit3(data[3]), .countUp(countUp),
        .parallel_count_enable_n(linkEn_n), .trickle_count_enable_n(linkEn_n),
        .count_bit0(qB[0]), .count_bit1(qB[1]), .count_bit2(qB[2]), .count_bit3(qB[3]),
        .ripple_carry_out_n(carryB_n));

    // =========================================
    // reference model
    function automatic logic [3:0] nxt(logic [3:0] q, logic dec, logic p, logic t, logic ld);
        logic [3:0] top;
        top = dec ? DECADE_MAX : BINARY_MAX;
        if (!clockEnable) return q;
        if (!ld) return data;
        if (p || t) return q;
        if (countUp) return (q >= top) ? COUNT_ZERO : q + COUNT_ONE;
        return (q == COUNT_ZERO) ? top : q - COUNT_ONE;
    endfunction

    function automatic logic cy(logic [3:0] q, logic dec, logic t);
        if (t) return 1'b1;
        if (countUp) return q != (dec ? DECADE_MAX : BINARY_MAX);
        return q != COUNT_ZERO;
    endfunction

    // load seen by both stages: plain pin, or predicted cascade carry in reload mode
    function automatic logic ld_exp();
        if (reload) return cy(expB, 1'b0, cy(expD, 1'b1, enT_n));
        return load_n;
    endfunction

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            expD <= COUNT_RESET;
            expB <= COUNT_RESET;
        end else begin
            expD <= nxt(expD, 1'b1, enP_n, enT_n, ld_exp());
            expB <= nxt(expB, 1'b0, cy(expD, 1'b1, enT_n), cy(expD, 1'b1, enT_n), ld_exp());
        end
    end

    // =========================================
    // compare and report
    task automatic check_count(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t count %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_carry(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t carry %b expected %b", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    always @(negedge clock) begin
        if (reset_n) begin
            check_count(qD, expD);
            check_count(qB, expB);
            check_carry(carryD_n, cy(expD, 1'b1, enT_n));
            check_carry(carryB_n, cy(expB, 1'b0, cy(expD, 1'b1, enT_n)));
        end
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            $display("[FAIL] %0t run did not finish", $time);
            print_verdict;
        end
    end

    // =========================================
    // stimulus
    task automatic drive(input logic ld, input logic [3:0] d, input logic up,
                         input logic p, input logic t, input logic ce);
        @(posedge clock);
        load_n      <= ld;
        data        <= d;
        countUp     <= up;
        enP_n       <= p;
        enT_n       <= t;
        clockEnable <= ce;
    endtask

    initial begin
        void'($urandom(52));
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        drive(1'b0, 4'hd, 1'b1, 1'b0, 1'b0, 1'b1);
        repeat (6) drive(1'b1, 4'hd, 1'b1, 1'b0, 1'b0, 1'b1);
        $display("test load and count up done");
        drive(1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1);
        repeat (4) drive(1'b1, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1);
        $display("test count down wrap done");
        drive(1'b0, 4'h9, 1'b1, 1'b0, 1'b0, 1'b1);
        drive(1'b1, 4'h9, 1'b1, 1'b1, 1'b0, 1'b1);
        drive(1'b1, 4'h9, 1'b1, 1'b0, 1'b1, 1'b1);
        drive(1'b1, 4'h9, 1'b0, 1'b0, 1'b0, 1'b0);
        drive(1'b1, 4'h9, 1'b0, 1'b0, 1'b0, 1'b1);
        $display("test inhibit and direction done");
        drive(1'b0, 4'h9, 1'b1, 1'b0, 1'b0, 1'b1);
        drive(1'b1, 4'h9, 1'b1, 1'b0, 1'b0, 1'b1);
        reload <= 1'b1;
        repeat (70) drive(1'b1, 4'h9, 1'b1, 1'b0, 1'b0, 1'b1);
        reload <= 1'b0;
        $display("test reload on carry done");
        repeat (900) drive($urandom_range(0, 7) != 0, 4'($urandom), 1'($urandom),
            $urandom_range(0, 3) == 0, $urandom_range(0, 3) == 0,
            $urandom_range(0, 9) != 0);
        $display("test random done");
        repeat (2) @(posedge clock);
        print_verdict;
    end
endmodule
